// >>> flsps_map.svh
// Register offsets, field positions and timing constants of the flash self-programming sequencer
// Operation
// - Flash rows hold 128 instruction words; one row is programmed per operation.
// - Erase unit is a page of eight rows, 1024 words.
// - Pages align on 3072-byte and rows on 384-byte boundaries.
// - Holding buffer keeps 128 words; table writes never touch the array.
// - Each table write is one word and takes two cycles.
// - Setting start bit 15 launches the selected operation, internally timed.
// - Hardware clears the start bit when the operation ends.
// - A completion interrupt request is raised at the end.
// - The CPU is stalled while a user flash operation runs.
// - Interrupts arriving during a stalling operation stay pending until it ends.
// - Work on the other flash region proceeds without stalling the CPU.
// - Power-on or brown-out reset aborts the running operation at once.
// - Pin, software, watchdog, trap, mismatch, opcode resets wait for completion.
// - Reprogrammed configuration words act only after a later reset.
// - Erasing the last page also clears the configuration words.
// - Page erase ignores the 11 low address bits.
// - After a valid key, start is accepted only on the very next access.
// - Operation select decodes erase, row, word pair, config, bulk primary, bulk auxiliary.
// - Operations run only while the program enable gate is set.
// - Target address is 24 bits: high register 8 bits, low register 16.
`ifndef FLSPS_MAP_SVH
`define FLSPS_MAP_SVH
`define FLSPS_OFS_CTRL    5'h00
`define FLSPS_OFS_KEY     5'h04
`define FLSPS_OFS_ADRLO   5'h08
`define FLSPS_OFS_ADRHI   5'h0c
`define FLSPS_OFS_TBLADR  5'h10
`define FLSPS_OFS_TBLLO   5'h14
`define FLSPS_OFS_TBLHI   5'h18
`define FLSPS_BIT_START   15
`define FLSPS_BIT_GATE    14
`define FLSPS_BIT_ERR     13
`define FLSPS_BIT_IDLE    12
`define FLSPS_KEY_FIRST   8'h55
`define FLSPS_KEY_SECOND  8'haa
`define FLSPS_OP_CFG      4'h0
`define FLSPS_OP_PAIR     4'h1
`define FLSPS_OP_ROW      4'h2
`define FLSPS_OP_PAGE     4'h3
`define FLSPS_OP_AUXBULK  4'ha
`define FLSPS_OP_PRIBULK  4'hd
`define FLSPS_ROW_WORDS   128
`define FLSPS_PAIR_WORDS  2
`define FLSPS_PAGE_MASK   24'hfff800
`define FLSPS_ROW_MASK    24'hffff00
`define FLSPS_PAIR_MASK   24'hfffffc
`define FLSPS_CFG_BIT     23
`define FLSPS_CLK_MHZ     200
`define FLSPS_ERASE_US    20
`define FLSPS_PROG_US     2
`endif

// >>> flsps_pkg.sv
// Shared types of the flash self-programming sequencer
package flsps_pkg;
  typedef enum logic [1:0] {FLSPS_WRITE, FLSPS_ERASE_PAGE, FLSPS_ERASE_PRI, FLSPS_ERASE_AUX} flsps_kind_t;
  typedef struct packed {
    logic        valid;
    flsps_kind_t kind;
    logic        cfg_clear;
    logic [23:0] addr;
    logic [23:0] data;
  } flsps_cmd_t;
  typedef enum {FLSPS_IDLE, FLSPS_LOAD, FLSPS_WAIT} flsps_state_t;
  typedef enum {FLSPS_KEY_NONE, FLSPS_KEY_HALF, FLSPS_KEY_ARMED} flsps_key_t;
endpackage

// >>> flsps_hold_buf.sv
// Holding buffer for one row of programming data
`timescale 1ns/100ps
module flsps_hold_buf #(
  parameter int WORDS = 128,
  parameter int AW    = 7
) (
  input  wire logic          mclk,
  input  wire logic          wr_lo,
  input  wire logic          wr_hi,
  input  wire logic [AW-1:0] wr_idx,
  input  wire logic [15:0]   wr_data,
  input  wire logic [AW-1:0] rd_idx,
  output logic [23:0]        rd_data
);
  logic [23:0] mem [WORDS];

  // Per-entry lanes: low word and high byte written separately
  for (genvar i = 0; i < WORDS; i++) begin : g_ent
    always_ff @(posedge mclk) begin
      if (wr_lo && wr_idx == AW'(i)) begin
        mem[i][15:0] <= wr_data;
      end
      if (wr_hi && wr_idx == AW'(i)) begin
        mem[i][23:16] <= wr_data[7:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    rd_data <= mem[rd_idx];
  end
endmodule

// >>> flsps_seq.sv
// Flash self-programming sequencer with Avalon-MM register slave
//
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "flsps_map.svh"
module flsps_seq #(
  parameter int ROW_WORDS    = `FLSPS_ROW_WORDS,
  parameter int ERASE_CYCLES = `FLSPS_ERASE_US * `FLSPS_CLK_MHZ,
  parameter int PROG_CYCLES  = `FLSPS_PROG_US * `FLSPS_CLK_MHZ,
  parameter logic [23:0] LAST_PAGE = 24'h07f800,
  parameter logic [23:0] AUX_BASE  = 24'h7fc000
) (
  input  wire logic                mclk,
  input  wire logic                reset,
  input  wire logic [4:0]          address,
  input  wire logic                read,
  input  wire logic                write,
  input  wire logic [31:0]         writedata,
  output logic [31:0]              readdata,
  output logic                     waitrequest,
  input  wire logic                brownout_reset,
  input  wire logic [5:0]          deferred_reset_in,
  input  wire logic                exec_from_aux,
  output logic                     sys_reset_req,
  output logic                     cpu_stall,
  output logic                     irq_hold,
  output logic                     done_irq,
  output logic                     flash_abort,
  output logic                     cfg_reload_pending,
  output flsps_pkg::flsps_cmd_t    flash_cmd
);
  localparam int AW = $clog2(ROW_WORDS);
  localparam logic [31:0] ERASE_CNT = 32'(ERASE_CYCLES);
  localparam logic [31:0] PROG_CNT  = 32'(PROG_CYCLES);

  flsps_pkg::flsps_state_t state, next_state;
  flsps_pkg::flsps_key_t   key, next_key;
  logic        start, next_start;
  logic        gate, next_gate;
  logic        err, next_err;
  logic        idle_stop, next_idle_stop;
  logic [3:0]  op, next_op;
  logic [15:0] adr_lo, next_adr_lo;
  logic [7:0]  adr_hi, next_adr_hi;
  logic [23:0] tbl_adr, next_tbl_adr;
  logic        wait_q, next_wait_q;
  logic [31:0] next_readdata;
  logic [AW:0] cnt, next_cnt;
  logic [AW:0] total, next_total;
  logic        pipe_v, next_pipe_v;
  logic [23:0] pipe_adr, next_pipe_adr;
  logic [23:0] base, next_base;
  logic [31:0] timer, next_timer;
  logic [5:0]  rst_pend, next_rst_pend;
  logic        next_sys_reset_req;
  logic        next_cpu_stall;
  logic        next_irq_hold;
  logic        next_done_irq;
  logic        next_flash_abort;
  logic        next_cfg_pend;
  flsps_pkg::flsps_cmd_t next_cmd;
  logic        buf_wr_lo, buf_wr_hi;
  logic [23:0] buf_rd_data;
  logic        take, wr_take, rd_take;
  logic [23:0] target;
  logic        start_try, start_ok, op_known, aux_target;

  // Writes act on the edge where waitrequest is seen low; read data is
  // captured one edge earlier so that it already stands there
  assign take    = (read || write) && wait_q;
  assign wr_take = write && wait_q;
  assign rd_take = read && !wait_q;
  assign target  = {adr_hi, adr_lo};
  assign buf_wr_lo = wr_take && address == `FLSPS_OFS_TBLLO;
  assign buf_wr_hi = wr_take && address == `FLSPS_OFS_TBLHI;

  always_comb begin
    op_known = 1'b0;
    case (writedata[3:0])
      `FLSPS_OP_CFG, `FLSPS_OP_PAIR, `FLSPS_OP_ROW, `FLSPS_OP_PAGE,
      `FLSPS_OP_AUXBULK, `FLSPS_OP_PRIBULK: op_known = 1'b1;
      default: op_known = 1'b0;
    endcase
  end

  assign start_try = wr_take && address == `FLSPS_OFS_CTRL && writedata[`FLSPS_BIT_START] && !start;
  // Gate comes from the same write, so a single start store with the gate set works
  assign start_ok  = start_try && key == flsps_pkg::FLSPS_KEY_ARMED
                     && writedata[`FLSPS_BIT_GATE] && op_known;

  // Every access is answered on its second cycle, giving two-cycle table writes
  always_comb begin
    next_wait_q   = wait_q;
    next_readdata = readdata;
    if (read || write) begin
      next_wait_q = !wait_q;
    end
    if (rd_take) begin
      if (address == `FLSPS_OFS_CTRL) begin
        next_readdata = 32'h0;
        next_readdata[`FLSPS_BIT_START] = start;
        next_readdata[`FLSPS_BIT_GATE]  = gate;
        next_readdata[`FLSPS_BIT_ERR]   = err;
        next_readdata[`FLSPS_BIT_IDLE]  = idle_stop;
        next_readdata[3:0]              = op;
      end else if (address == `FLSPS_OFS_ADRLO) begin
        next_readdata = {16'h0, adr_lo};
      end else if (address == `FLSPS_OFS_ADRHI) begin
        next_readdata = {24'h0, adr_hi};
      end else if (address == `FLSPS_OFS_TBLADR) begin
        next_readdata = {8'h0, tbl_adr};
      end else begin
        next_readdata = 32'h0;
      end
    end
  end

  always_comb begin
    next_state     = state;
    next_key       = key;
    next_start     = start;
    next_gate      = gate;
    next_err       = err;
    next_idle_stop = idle_stop;
    next_op        = op;
    next_adr_lo    = adr_lo;
    next_adr_hi    = adr_hi;
    next_tbl_adr   = tbl_adr;
    next_cnt       = cnt;
    next_total     = total;
    next_pipe_v    = 1'b0;
    next_pipe_adr  = pipe_adr;
    next_base      = base;
    next_timer     = timer;
    next_done_irq  = 1'b0;
    next_flash_abort = 1'b0;
    next_cfg_pend  = cfg_reload_pending;
    next_cmd       = '0;
    next_rst_pend  = rst_pend | deferred_reset_in;
    // Clear first so a configuration change in the same cycle wins
    if (sys_reset_req) begin
      next_cfg_pend = 1'b0;
    end
    // Key window lasts exactly one access after the second key
    if (take && key == flsps_pkg::FLSPS_KEY_ARMED) begin
      next_key = flsps_pkg::FLSPS_KEY_NONE;
    end
    if (wr_take) begin
      if (address == `FLSPS_OFS_KEY) begin
        if (writedata[7:0] == `FLSPS_KEY_FIRST) begin
          next_key = flsps_pkg::FLSPS_KEY_HALF;
        end else if (writedata[7:0] == `FLSPS_KEY_SECOND && key == flsps_pkg::FLSPS_KEY_HALF) begin
          next_key = flsps_pkg::FLSPS_KEY_ARMED;
        end else begin
          next_key = flsps_pkg::FLSPS_KEY_NONE;
        end
      end else if (address == `FLSPS_OFS_CTRL && state == flsps_pkg::FLSPS_IDLE) begin
        next_gate      = writedata[`FLSPS_BIT_GATE];
        next_idle_stop = writedata[`FLSPS_BIT_IDLE];
        next_op        = writedata[3:0];
        if (!writedata[`FLSPS_BIT_ERR]) begin
          next_err = 1'b0;
        end
      end else if (address == `FLSPS_OFS_ADRLO && state == flsps_pkg::FLSPS_IDLE) begin
        next_adr_lo = writedata[15:0];
      end else if (address == `FLSPS_OFS_ADRHI && state == flsps_pkg::FLSPS_IDLE) begin
        next_adr_hi = writedata[7:0];
      end else if (address == `FLSPS_OFS_TBLADR) begin
        next_tbl_adr = writedata[23:0];
      end else if (address == `FLSPS_OFS_TBLHI) begin
        // Sequential loading advances by one instruction after the high part
        next_tbl_adr = tbl_adr + 24'h2;
      end
    end
    // Error set placed after the clear so a concurrent event wins
    if (start_try && !start_ok) begin
      next_err = 1'b1;
    end
    if (start_ok) begin
      next_start = 1'b1;
      next_cnt   = '0;
      case (writedata[3:0])
        `FLSPS_OP_ROW: begin
          next_base  = target & `FLSPS_ROW_MASK;
          next_total = (AW+1)'(ROW_WORDS);
          next_state = flsps_pkg::FLSPS_LOAD;
        end
        `FLSPS_OP_PAIR: begin
          next_base  = target & `FLSPS_PAIR_MASK;
          next_total = (AW+1)'(`FLSPS_PAIR_WORDS);
          next_state = flsps_pkg::FLSPS_LOAD;
        end
        `FLSPS_OP_CFG: begin
          next_base     = target;
          next_total    = (AW+1)'(1);
          next_state    = flsps_pkg::FLSPS_LOAD;
          next_cfg_pend = 1'b1;
        end
        default: begin
          next_cmd.valid = 1'b1;
          next_cmd.addr  = target & `FLSPS_PAGE_MASK;
          if (writedata[3:0] == `FLSPS_OP_PAGE) begin
            next_cmd.kind      = flsps_pkg::FLSPS_ERASE_PAGE;
            next_cmd.cfg_clear = (target & `FLSPS_PAGE_MASK) == LAST_PAGE;
            next_cfg_pend      = next_cfg_pend | ((target & `FLSPS_PAGE_MASK) == LAST_PAGE);
          end else if (writedata[3:0] == `FLSPS_OP_AUXBULK) begin
            next_cmd.kind = flsps_pkg::FLSPS_ERASE_AUX;
          end else begin
            next_cmd.kind      = flsps_pkg::FLSPS_ERASE_PRI;
            next_cmd.cfg_clear = 1'b1;
            next_cfg_pend      = 1'b1;
          end
          next_timer = ERASE_CNT - 32'h1;
          next_state = flsps_pkg::FLSPS_WAIT;
        end
      endcase
    end
    case (state)
      flsps_pkg::FLSPS_LOAD: begin
        // Buffer read has one cycle latency; address travels alongside
        if (cnt < total) begin
          next_pipe_v   = 1'b1;
          next_pipe_adr = base + {15'h0, cnt, 1'b0};
          next_cnt      = cnt + (AW+1)'(1);
        end else if (!pipe_v) begin
          next_timer = PROG_CNT - 32'h1;
          next_state = flsps_pkg::FLSPS_WAIT;
        end
        if (pipe_v) begin
          next_cmd.valid = 1'b1;
          next_cmd.kind  = flsps_pkg::FLSPS_WRITE;
          next_cmd.addr  = pipe_adr;
          next_cmd.data  = buf_rd_data;
        end
      end
      flsps_pkg::FLSPS_WAIT: begin
        if (timer == 32'h0) begin
          next_start    = 1'b0;
          next_done_irq = 1'b1;
          next_state    = flsps_pkg::FLSPS_IDLE;
        end else begin
          next_timer = timer - 32'h1;
        end
      end
      default: begin
      end
    endcase
    // Brown-out kills the operation outright; the flag tells software to repeat
    if (brownout_reset) begin
      next_state       = flsps_pkg::FLSPS_IDLE;
      next_start       = 1'b0;
      next_pipe_v      = 1'b0;
      next_cmd         = '0;
      next_flash_abort = state != flsps_pkg::FLSPS_IDLE;
      next_err         = next_err | (state != flsps_pkg::FLSPS_IDLE);
      next_key         = flsps_pkg::FLSPS_KEY_NONE;
    end
    // Deferred resets are released only once the array is quiet
    next_sys_reset_req = |rst_pend && next_state == flsps_pkg::FLSPS_IDLE;
    if (sys_reset_req) begin
      next_rst_pend = deferred_reset_in;
    end
    // Region of the operation being started, not of the previous one;
    // configuration space is never the auxiliary region
    aux_target = (next_op == `FLSPS_OP_AUXBULK)
                 || (next_op != `FLSPS_OP_PRIBULK && target >= AUX_BASE && !target[`FLSPS_CFG_BIT]);
    next_cpu_stall = next_state != flsps_pkg::FLSPS_IDLE && (aux_target == exec_from_aux);
    next_irq_hold  = next_cpu_stall;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state       <= flsps_pkg::FLSPS_IDLE;
      key         <= flsps_pkg::FLSPS_KEY_NONE;
      start       <= 1'b0;
      gate        <= 1'b0;
      err         <= 1'b0;
      idle_stop   <= 1'b0;
      op          <= 4'h0;
      adr_lo      <= 16'h0;
      adr_hi      <= 8'h0;
      tbl_adr     <= 24'h0;
      wait_q      <= 1'b0;
      readdata    <= 32'h0;
      cnt         <= '0;
      total       <= '0;
      pipe_v      <= 1'b0;
      pipe_adr    <= 24'h0;
      base        <= 24'h0;
      timer       <= 32'h0;
      rst_pend    <= 6'h0;
      sys_reset_req <= 1'b0;
      cpu_stall   <= 1'b0;
      irq_hold    <= 1'b0;
      done_irq    <= 1'b0;
      flash_abort <= 1'b0;
      cfg_reload_pending <= 1'b0;
      flash_cmd   <= '0;
    end else begin
      state       <= next_state;
      key         <= next_key;
      start       <= next_start;
      gate        <= next_gate;
      err         <= next_err;
      idle_stop   <= next_idle_stop;
      op          <= next_op;
      adr_lo      <= next_adr_lo;
      adr_hi      <= next_adr_hi;
      tbl_adr     <= next_tbl_adr;
      wait_q      <= next_wait_q;
      readdata    <= next_readdata;
      cnt         <= next_cnt;
      total       <= next_total;
      pipe_v      <= next_pipe_v;
      pipe_adr    <= next_pipe_adr;
      base        <= next_base;
      timer       <= next_timer;
      rst_pend    <= next_rst_pend;
      sys_reset_req <= next_sys_reset_req;
      cpu_stall   <= next_cpu_stall;
      irq_hold    <= next_irq_hold;
      done_irq    <= next_done_irq;
      flash_abort <= next_flash_abort;
      cfg_reload_pending <= next_cfg_pend;
      flash_cmd   <= next_cmd;
    end
  end

  assign waitrequest = !wait_q;

  flsps_hold_buf #(
    .WORDS (ROW_WORDS),
    .AW    (AW)
  ) u_buf (
    .mclk    (mclk),
    .wr_lo   (buf_wr_lo),
    .wr_hi   (buf_wr_hi),
    .wr_idx  (tbl_adr[AW:1]),
    .wr_data (writedata[15:0]),
    .rd_idx  (cnt[AW-1:0]),
    .rd_data (buf_rd_data)
  );

  logic [AW+1:0] wr_seen;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wr_seen <= '0;
    end else if (state == flsps_pkg::FLSPS_IDLE) begin
      wr_seen <= '0;
    end else if (flash_cmd.valid && flash_cmd.kind == flsps_pkg::FLSPS_WRITE) begin
      wr_seen <= wr_seen + (AW+2)'(1);
    end
  end

  property p_row_count;
    @(posedge mclk) disable iff (reset)
    (state == flsps_pkg::FLSPS_WAIT && op == `FLSPS_OP_ROW && $past(state) == flsps_pkg::FLSPS_LOAD)
      |-> wr_seen == (AW+2)'(ROW_WORDS);
  endproperty
  a_row_count: assert property (p_row_count) else $error("row program did not issue a full row");

  property p_two_cycle;
    @(posedge mclk) disable iff (reset)
    (write && waitrequest) |=> !waitrequest ##1 waitrequest;
  endproperty
  a_two_cycle: assert property (p_two_cycle) else $error("access not answered in two cycles");

  property p_start_armed;
    @(posedge mclk) disable iff (reset)
    $rose(start) |-> $past(key) == flsps_pkg::FLSPS_KEY_ARMED && $past(writedata[`FLSPS_BIT_GATE]);
  endproperty
  a_start_armed: assert property (p_start_armed) else $error("start without key or gate");

  property p_bad_start_err;
    @(posedge mclk) disable iff (reset)
    (start_try && !start_ok && !brownout_reset) |=> err && !start;
  endproperty
  a_bad_start_err: assert property (p_bad_start_err) else $error("bad start did not flag error");

  property p_done_clears;
    @(posedge mclk) disable iff (reset)
    done_irq |-> !start && state == flsps_pkg::FLSPS_IDLE && $past(start);
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("completion with start still set");

  property p_page_align;
    @(posedge mclk) disable iff (reset)
    (flash_cmd.valid && flash_cmd.kind == flsps_pkg::FLSPS_ERASE_PAGE) |-> flash_cmd.addr[10:0] == 11'h0;
  endproperty
  a_page_align: assert property (p_page_align) else $error("page erase address not aligned");

  property p_stall_busy;
    @(posedge mclk) disable iff (reset)
    cpu_stall |-> state != flsps_pkg::FLSPS_IDLE && irq_hold;
  endproperty
  a_stall_busy: assert property (p_stall_busy) else $error("stall outside an operation");

  property p_reset_defer;
    @(posedge mclk) disable iff (reset)
    sys_reset_req |-> state == flsps_pkg::FLSPS_IDLE && !start;
  endproperty
  a_reset_defer: assert property (p_reset_defer) else $error("reset released during operation");

  property p_brownout;
    @(posedge mclk) disable iff (reset)
    brownout_reset |=> state == flsps_pkg::FLSPS_IDLE && !start && !flash_cmd.valid;
  endproperty
  a_brownout: assert property (p_brownout) else $error("brown-out did not abort");
endmodule

// >>> flsps_flash_model.sv
// Flash array stand-in that records the commands issued by the sequencer
`timescale 1ns/100ps
module flsps_flash_model (
  input  wire logic                  mclk,
  input  wire flsps_pkg::flsps_cmd_t cmd,
  output int                         n_cmd,
  output logic [23:0]                last_addr,
  output logic [23:0]                last_data,
  output logic [1:0]                 last_kind
);
  initial n_cmd = 0;
  // Takes one command a cycle; the sequencer alone owns the timing
  always @(posedge mclk) begin
    if (cmd.valid === 1'b1) begin
      n_cmd     <= n_cmd + 1;
      last_addr <= cmd.addr;
      last_data <= cmd.data;
      last_kind <= cmd.kind;
    end
  end
endmodule

// >>> flash_self_program_sequencer_tb.sv
// Self-checking bench of the flash self-programming sequencer
`timescale 1ns/100ps
module flash_self_program_sequencer_tb;
  logic                  mclk, reset, read, write, brownout_reset, exec_from_aux;
  logic                  waitrequest, sys_reset_req, cpu_stall, irq_hold, done_irq, flash_abort, cfg_pend;
  logic [4:0]            address;
  logic [5:0]            deferred_reset_in;
  logic [31:0]           writedata, readdata, rd;
  logic [23:0]           last_addr, last_data;
  logic [1:0]            last_kind;
  flsps_pkg::flsps_cmd_t flash_cmd;
  int                    n_cmd, n_abort, base, num_errors, samples_checked;
  logic [3:0]            ops[4] = '{4'hd, 4'ha, 4'h1, 4'h0};
  logic [23:0]           adrs[4] = '{24'h0, 24'h0, 24'h000104, 24'h800000};

  flsps_seq #(.ERASE_CYCLES(40), .PROG_CYCLES(20)) uut (.mclk(mclk), .reset(reset), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .brownout_reset(brownout_reset), .deferred_reset_in(deferred_reset_in), .exec_from_aux(exec_from_aux),
    .sys_reset_req(sys_reset_req), .cpu_stall(cpu_stall), .irq_hold(irq_hold), .done_irq(done_irq),
    .flash_abort(flash_abort), .cfg_reload_pending(cfg_pend), .flash_cmd(flash_cmd));
  flsps_flash_model flash (.mclk(mclk), .cmd(flash_cmd), .n_cmd(n_cmd), .last_addr(last_addr),
    .last_data(last_data), .last_kind(last_kind));

  always #2.5 mclk = ~mclk;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  always @(posedge mclk) begin
    if (flash_abort === 1'b1) n_abort++;
    if (reset === 1'b0) chk("irq_hold", irq_hold, cpu_stall);
  end

  // Holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    read      <= ~w;
    write     <= w;
    address   <= a;
    writedata <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (n >= 20) chk("waitrequest", waitrequest, 0);
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  // Offsets: 0x00 control, 0x04 key, 0x08/0x0c target address
  task automatic start(input logic [23:0] a, input logic [31:0] c);
    bus(1, 5'h0c, {24'h0, a[23:16]});
    bus(1, 5'h08, {16'h0, a[15:0]});
    bus(1, 5'h04, 32'h55);
    bus(1, 5'h04, 32'haa);
    bus(1, 5'h00, c);
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (done_irq !== 1'b1 && n < 2000) begin
      @(posedge mclk);
      n++;
    end
    chk("done_irq", done_irq, 1);
    @(posedge mclk);
  endtask

  // Expects start clear and error set, then clears the error
  task automatic refused(input string nm);
    bus(0, 5'h00, 0);
    chk(nm, {rd[15], rd[13]}, 2'b01);
    chk("no_cmd", n_cmd, base);
    bus(1, 5'h00, 32'h0003);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    #100000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    mclk = 0; reset = 1; read = 0; write = 0; address = 0; writedata = 0;
    brownout_reset = 0; exec_from_aux = 0; deferred_reset_in = 0;
    num_errors = 0; samples_checked = 0; n_abort = 0;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    bus(0, 5'h00, 0);
    chk("ctrl_reset", rd, 0);
    bus(0, 5'h1c, 0);
    chk("unmapped", rd, 0);
    base = n_cmd;
    bus(1, 5'h00, 32'hc003);
    refused("no_key");
    start(24'h0, 32'h8003);
    refused("gate_off");
    bus(1, 5'h04, 32'h55);
    bus(1, 5'h04, 32'haa);
    bus(1, 5'h08, 0);
    bus(1, 5'h00, 32'hc003);
    refused("late_start");
    start(24'h0, 32'hc005);
    refused("reserved_op");
    $display("refusal test done");
    start(24'h022222, 32'hc003);
    repeat (2) @(posedge mclk);
    chk("stall", cpu_stall, 1);
    bus(0, 5'h00, 0);
    chk("busy", rd[15], 1);
    wait_done();
    chk("erase_cnt", n_cmd - base, 1);
    chk("erase_kind", last_kind, 1);
    chk("erase_adr", last_addr, 24'h022000);
    chk("stall_end", cpu_stall, 0);
    bus(0, 5'h00, 0);
    chk("start_clr", rd[15], 0);
    $display("page erase test done");
    base = n_cmd;
    bus(1, 5'h10, 0);
    for (int i = 0; i < 128; i++) begin
      bus(1, 5'h14, 32'(i * 3));
      bus(1, 5'h18, 32'(i));
    end
    chk("latch_only", n_cmd, base);
    start(24'h022222, 32'hc002);
    wait_done();
    chk("row_cnt", n_cmd - base, 128);
    chk("row_adr", last_addr, 24'h0222fe);
    chk("row_data", last_data, 24'h7f017d);
    chk("cfg_idle", cfg_pend, 0);
    $display("row program test done");
    for (int k = 0; k < 4; k++) begin
      exec_from_aux <= (k == 0);
      start(adrs[k], {28'h000c00, ops[k]});
      repeat (2) @(posedge mclk);
      chk("region_stall", cpu_stall, k > 1);
      wait_done();
      chk("op_kind", last_kind, k < 2 ? 2 + k : 0);
    end
    exec_from_aux <= 1'b0;
    chk("cfg_pend", cfg_pend, 1);
    $display("operation select test done");
    start(24'h0, 32'hc003);
    repeat (4) @(posedge mclk);
    brownout_reset <= 1'b1;
    @(posedge mclk);
    brownout_reset <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("abort", n_abort, 1);
    bus(0, 5'h00, 0);
    chk("abort_ctrl", {rd[15], rd[13]}, 2'b01);
    bus(1, 5'h00, 32'h0003);
    start(24'h0, 32'hc003);
    repeat (3) @(posedge mclk);
    deferred_reset_in <= 6'h04;
    @(posedge mclk);
    deferred_reset_in <= 6'h00;
    repeat (3) @(posedge mclk);
    chk("defer_busy", sys_reset_req, 0);
    wait_done();
    chk("defer_after", sys_reset_req, 1);
    repeat (2) @(posedge mclk);
    chk("cfg_reload", cfg_pend, 0);
    $display("reset test done");
    reset <= 1'b1;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    bus(0, 5'h00, 0);
    chk("ctrl_rereset", rd, 0);
    start(24'h07f9ab, 32'hc003);
    wait_done();
    chk("last_page_adr", last_addr, 24'h07f800);
    chk("last_page_cfg", cfg_pend, 1);
    $display("last page test done");
    report_and_stop();
  end
endmodule
